//--- rtl/csp_defines.svh
/*
 * Constants of the configuration load port: codes, counts and timings.
 * Assumes the system clock runs at 25 MHz and that the user includes
 * this file before the package and modules.
 */
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// system clock period and program request minimum width
`define CSP_CLK_NS 40
`define CSP_PROG_MIN_NS 500
`define CSP_PROG_CYC ((`CSP_PROG_MIN_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS)

// memory clearing time and start-up clocks
`define CSP_CLEAR_CYC 16'h0040
`define CSP_STARTUP_CLKS 4'h8

// flash clock half period in system clocks
`define CSP_FLASH_HALF 4

// mode select codes
`define CSP_MODE_PAR 3'h6
`define CSP_MODE_SER 3'h7
`define CSP_MODE_FLASH 3'h1

// flash variant codes, read commands and header lengths
`define CSP_FV_FAST 3'h7
`define CSP_FV_READ 3'h5
`define CSP_CMD_READ 8'h03
`define CSP_CMD_FAST 8'h0B
`define CSP_ADDR_BYTES 3
`define CSP_FAST_DUMMY 1

// check byte polynomial and seed
`define CSP_CRC_POLY 8'h07
`define CSP_CRC_INIT 8'h00

`endif

//--- rtl/csp_link.sv
/*
 * Link side of the load port, clocked by the host's configuration clock.
 * Assumes control levels come from the system domain and are synced here.
 */
`timescale 1ns/1ps
`include "csp_defines.svh"

module csp_link
   import csp_pkg::*;
(
   // link clock and reset
   input wire logic link_clk,
   input wire logic rst,
   // levels from the system domain
   input wire logic link_en,
   input wire logic serial_sel,
   input wire logic startup_req,
   input wire logic readback_en,
   input wire logic [7:0] readback_byte,
   input wire logic ack_tgl,
   // host pins on the link clock
   input wire csp_par_s par,
   input wire logic serial_din,
   // towards the system domain
   output logic req_tgl,
   output logic [7:0] hold_byte,
   output logic startup_done,
   // host-facing outputs
   output logic busy,
   output logic [7:0] rb_data,
   output logic rb_oe
);

   typedef struct packed {
      logic [6:0] shift;
      logic [2:0] bit_cnt;
      logic [7:0] hold;
      logic req;
      logic [3:0] su_cnt;
      logic su_done;
      logic [7:0] rb;
      logic rb_oe;
   } csp_link_s;

   csp_link_s r_q;
   csp_link_s r_d;
   logic [4:0] s;
   logic busy_c;

   csp_sync #(.W(5)) u_sync (
      .clk(link_clk),
      .rst(rst),
      .d({link_en, serial_sel, startup_req, readback_en, ack_tgl}),
      .q(s)
   );

   // busy while the held byte is not yet taken by the system side
   assign busy_c = r_q.req != s[0];

   always_comb begin
      r_d = r_q;
      if (!s[4]) begin
         r_d.bit_cnt = 3'h0;
      end else if (s[3]) begin
         // msb first, one bit per rising edge
         r_d.shift = {r_q.shift[5:0], serial_din};
         r_d.bit_cnt = r_q.bit_cnt + 3'h1;
         if (r_q.bit_cnt == 3'h7 && !busy_c) begin
            r_d.hold = {r_q.shift, serial_din};
            r_d.req = !r_q.req;
         end
      end else if (!par.cs_n && !par.read_write_n && !busy_c) begin
         // one byte per edge while selected and not busy
         r_d.hold = par.data;
         r_d.req = !r_q.req;
      end
      // start-up needs host clocks past the bitstream
      if (!s[2]) begin
         r_d.su_cnt = 4'h0;
         r_d.su_done = 1'b0;
      end else if (r_q.su_cnt != `CSP_STARTUP_CLKS) begin
         r_d.su_cnt = r_q.su_cnt + 4'h1;
      end else begin
         r_d.su_done = 1'b1;
      end
      // readback byte is static once configured
      r_d.rb_oe = s[1] && !par.cs_n && par.read_write_n;
      if (s[1]) begin
         r_d.rb = readback_byte;
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign req_tgl = r_q.req;
   assign hold_byte = r_q.hold;
   assign startup_done = r_q.su_done;
   assign busy = busy_c;
   assign rb_data = r_q.rb;
   assign rb_oe = r_q.rb_oe;

endmodule // csp_link

//--- rtl/csp_pkg.sv
/*
 * Types shared by the configuration load port modules.
 * Assumes nothing of its surroundings.
 */
package csp_pkg;

   // load sequence states
   typedef enum logic [2:0] {
      CS_HOLD, CS_CLEAR, CS_LOAD, CS_STARTUP, CS_DONE, CS_ERROR
   } csp_state_e;

   // open-drain pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } csp_od_s;

   // parallel host pins
   typedef struct packed {
      logic cs_n;
      logic read_write_n;
      logic [7:0] data;
   } csp_par_s;

   // decoded flash variant
   typedef struct packed {
      logic ok;
      logic [7:0] cmd;
      logic [2:0] lead;
   } csp_variant_s;

endpackage

//--- rtl/csp_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a level that holds for several destination clocks.
 */
`timescale 1ns/1ps

module csp_sync #(
   parameter int W = 1
) (
   // destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } csp_sync_s;

   csp_sync_s r_q;
   csp_sync_s r_d;

   // first stage feeds only the second
   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.s2;

endmodule // csp_sync

//--- rtl/csp_top.sv
/*
 * Configuration load port: mode straps, program request, memory clear,
 * slave parallel and slave serial load, flash master load, check byte,
 * start-up, chaining and readback keep.
 * Assumes clk is 25 MHz, the configuration clock pin is a separate domain
 * in slave modes, and open-drain wires are resolved outside.
 */
`timescale 1ns/1ps
`include "csp_defines.svh"

// What this block does
// - mode 110 selects byte-wide slave load
// - mode 111 selects bit-serial slave load
// - mode 001 loads from flash, drives clock
// - variant pins pick read command, dummy bytes
// - mode pins sampled at init release
// - busy high means host holds byte
// - chip select out low once load ends with a matching check byte
// - init driven low while memory clears
// - check byte mismatch drives init low
// - done held low until successful configuration
// - long program request clears and restarts
// - no load start while program request low
// - config pins become user pins afterward
// - keep option leaves parallel port for readback in mode 110 only
// - pullup_disable low enables pull-ups while configuring
// - serial mode captures one bit per edge
module csp_top
   import csp_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic rst,
   // straps and options
   input wire logic [2:0] mode_select,
   input wire logic [2:0] flash_variant_select,
   input wire logic pullup_disable,
   input wire logic keep_port,
   input wire logic [15:0] load_length,
   // program request and open-drain status pins
   input wire logic program_request_n,
   input wire logic init_i,
   output csp_od_s init_pin,
   input wire logic done_i,
   output csp_od_s done_pin,
   // configuration clock pin
   input wire logic configuration_clock,
   output logic sclk_o,
   output logic sclk_oe,
   // slave parallel pins
   input wire csp_par_s par,
   output logic [7:0] data_o,
   output logic data_oe,
   output logic busy,
   output logic chip_select_out_n,
   // slave serial pin
   input wire logic serial_din,
   // flash pins
   output logic flash_select_n,
   output logic flash_mosi,
   input wire logic flash_miso,
   // status
   output logic pullup_enable,
   output logic user_io_enable,
   output logic configured,
   output logic crc_error
);

   typedef struct packed {
      csp_state_e st;
      logic [3:0] prog_cnt;
      logic [15:0] cnt;
      logic [2:0] mode;
      logic [15:0] byte_cnt;
      logic [7:0] crc;
      logic ack_tgl;
      logic link_en;
      logic startup;
      logic cso_n;
      logic crc_err;
      logic fl_act;
      logic fl_clk;
      logic [2:0] fl_div;
      logic [2:0] fl_bit;
      logic [2:0] fl_idx;
      logic [7:0] fl_tx;
      logic [7:0] fl_rx;
   } csp_top_s;

   localparam logic [3:0] PROG_LAST = 4'(`CSP_PROG_CYC - 1);
   localparam logic [2:0] HALF_LAST = 3'(`CSP_FLASH_HALF - 1);

   csp_top_s r_q;
   csp_top_s r_d;
   csp_variant_s var_c;
   logic byte_v;
   logic [7:0] byte_d;

   // synchronised pins
   logic [12:0] s;
   logic prog_s;
   logic init_s;
   logic done_s;
   logic pud_s;
   logic [2:0] mode_s;
   logic [2:0] fv_s;
   logic miso_s;
   logic req_s;
   logic su_s;

   // link side
   logic req_tgl;
   logic [7:0] hold_byte;
   logic su_done;

   // mode test shared by load start and link enable
   function automatic logic slave_mode(input logic [2:0] m);
      return m == `CSP_MODE_PAR || m == `CSP_MODE_SER;
   endfunction

   // variant pins pick command and header length
   function automatic csp_variant_s variant(input logic [2:0] fv);
      csp_variant_s r;
      r.ok = 1'b1;
      r.cmd = `CSP_CMD_READ;
      r.lead = 3'(1 + `CSP_ADDR_BYTES);
      if (fv == `CSP_FV_FAST) begin
         r.cmd = `CSP_CMD_FAST;
         r.lead = 3'(1 + `CSP_ADDR_BYTES + `CSP_FAST_DUMMY);
      end else if (fv != `CSP_FV_READ) begin
         r.ok = 1'b0;
      end
      return r;
   endfunction

   // bytewise check value, msb first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         if (r[7]) begin
            r = {r[6:0], 1'b0} ^ `CSP_CRC_POLY;
         end else begin
            r = {r[6:0], 1'b0};
         end
      end
      return r;
   endfunction

   // every system-side pin except keep_port and load_length, plus req_tgl and su_done, passes two flops before use
   csp_sync #(.W(13)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({program_request_n, init_i, done_i, pullup_disable, mode_select,
          flash_variant_select, flash_miso, req_tgl, su_done}),
      .q(s)
   );

   assign prog_s = s[12];
   assign init_s = s[11];
   assign done_s = s[10];
   assign pud_s = s[9];
   assign mode_s = s[8:6];
   assign fv_s = s[5:3];
   assign miso_s = s[2];
   assign req_s = s[1];
   assign su_s = s[0];

   // host clock domain: capture, busy, start-up clocks, readback
   csp_link u_link (
      .link_clk(configuration_clock),
      .rst(rst),
      .link_en(r_q.link_en),
      .serial_sel(r_q.mode == `CSP_MODE_SER),
      .startup_req(r_q.startup),
      .readback_en(r_q.st == CS_DONE && keep_port && r_q.mode == `CSP_MODE_PAR),
      .readback_byte(r_q.crc),
      .ack_tgl(r_q.ack_tgl),
      .par(par),
      .serial_din(serial_din),
      .req_tgl(req_tgl),
      .hold_byte(hold_byte),
      .startup_done(su_done),
      .busy(busy),
      .rb_data(data_o),
      .rb_oe(data_oe)
   );

   // sequence, flash master and loader
   always_comb begin
      r_d = r_q;
      var_c = variant(fv_s);
      byte_v = 1'b0;
      byte_d = hold_byte;
      // count how long the program request has been low
      if (!prog_s) begin
         if (r_q.prog_cnt != PROG_LAST) begin
            r_d.prog_cnt = r_q.prog_cnt + 4'h1;
         end
      end else begin
         r_d.prog_cnt = 4'h0;
      end
      // always acknowledge, so a stale toggle can never stall the link
      if (req_s != r_q.ack_tgl) begin
         r_d.ack_tgl = req_s;
         byte_v = r_q.link_en;
      end
      unique case (r_q.st)
         CS_HOLD: begin
            // restart only once the request returns high
            if (prog_s) begin
               r_d.st = CS_CLEAR;
               r_d.cnt = 16'h0000;
            end
         end
         CS_CLEAR: begin
            if (r_q.cnt != `CSP_CLEAR_CYC) begin
               r_d.cnt = r_q.cnt + 16'h0001; // init held low
            end else if (prog_s && init_s) begin
               // mode pins taken as the init wire rises; variant pins are read live
               r_d.mode = mode_s;
               r_d.byte_cnt = 16'h0000;
               r_d.crc = `CSP_CRC_INIT;
               r_d.st = CS_LOAD;
               r_d.link_en = slave_mode(mode_s);
               if (!slave_mode(mode_s) && mode_s != `CSP_MODE_FLASH) begin
                  r_d.st = CS_ERROR; // unused strap code
               end
            end
         end
         CS_LOAD: begin
            if (r_q.mode == `CSP_MODE_FLASH) begin
               if (!var_c.ok) begin
                  r_d.st = CS_ERROR; // reserved variant
               end else if (!r_q.fl_act) begin
                  // select the flash, first command bit on mosi
                  r_d.fl_act = 1'b1;
                  r_d.fl_tx = var_c.cmd;
                  r_d.fl_bit = 3'h0;
                  r_d.fl_idx = 3'h0;
                  r_d.fl_div = 3'h0;
                  r_d.fl_clk = 1'b0;
               end else if (r_q.fl_div != HALF_LAST) begin
                  r_d.fl_div = r_q.fl_div + 3'h1;
               end else begin
                  // clock made by dividing the system clock
                  r_d.fl_div = 3'h0;
                  r_d.fl_clk = !r_q.fl_clk;
                  if (!r_q.fl_clk) begin
                     // rising edge: sample; header bytes are skipped
                     r_d.fl_rx = {r_q.fl_rx[6:0], miso_s};
                     if (r_q.fl_bit == 3'h7 && r_q.fl_idx >= var_c.lead) begin
                        byte_v = 1'b1;
                        byte_d = {r_q.fl_rx[6:0], miso_s};
                     end
                  end else begin
                     // falling edge: next bit out, address is all zero
                     r_d.fl_bit = r_q.fl_bit + 3'h1;
                     r_d.fl_tx = {r_q.fl_tx[6:0], 1'b0};
                     if (r_q.fl_bit == 3'h7 && r_q.fl_idx != 3'h7) begin
                        r_d.fl_idx = r_q.fl_idx + 3'h1;
                     end
                  end
               end
            end
            if (byte_v) begin
               if (r_q.byte_cnt != load_length) begin
                  r_d.crc = crc8(r_q.crc, byte_d);
                  r_d.byte_cnt = r_q.byte_cnt + 16'h0001;
               end else if (byte_d == r_q.crc) begin
                  // own data complete: enable next device
                  r_d.st = CS_STARTUP;
                  r_d.cso_n = 1'b0;
                  r_d.link_en = 1'b0;
                  r_d.fl_act = 1'b0;
                  r_d.fl_clk = 1'b0;
                  r_d.startup = r_q.mode != `CSP_MODE_FLASH;
                  r_d.cnt = 16'h0000;
               end else begin
                  r_d.st = CS_ERROR; // init low on mismatch
                  r_d.crc_err = 1'b1;
                  r_d.link_en = 1'b0;
                  r_d.fl_act = 1'b0;
                  r_d.fl_clk = 1'b0;
               end
            end
         end
         CS_STARTUP: begin
            if (r_q.mode == `CSP_MODE_FLASH) begin
               if (r_q.cnt != 16'(`CSP_STARTUP_CLKS)) begin
                  r_d.cnt = r_q.cnt + 16'h0001;
               end else begin
                  r_d.st = CS_DONE;
               end
            end else if (su_s) begin
               // host clocks ran the start-up
               r_d.st = CS_DONE;
               r_d.startup = 1'b0;
            end
         end
         CS_DONE: begin
         end
         CS_ERROR: begin
         end
      endcase
      // a long enough low request aborts anything in flight
      if (!prog_s && r_q.prog_cnt == PROG_LAST) begin
         r_d.st = CS_HOLD;
         r_d.cnt = 16'h0000;
         r_d.link_en = 1'b0;
         r_d.startup = 1'b0;
         r_d.cso_n = 1'b1;
         r_d.crc_err = 1'b0;
         r_d.fl_act = 1'b0;
         r_d.fl_clk = 1'b0;
      end
   end

   // power-up behaves as a fresh clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
         r_q.st <= CS_CLEAR;
         r_q.cso_n <= 1'b1;
         r_q.crc <= `CSP_CRC_INIT;
      end else begin
         r_q <= r_d;
      end
   end

   // init driven low while clearing, held or failed
   assign init_pin.o = 1'b0;
   assign init_pin.oe = r_q.st == CS_HOLD || r_q.st == CS_ERROR ||
                        (r_q.st == CS_CLEAR && r_q.cnt != `CSP_CLEAR_CYC);

   // done released only after a good load and start-up
   assign done_pin.o = 1'b0;
   assign done_pin.oe = r_q.st != CS_DONE;

   // configuration clock driven only in flash mode
   assign sclk_o = r_q.fl_clk;
   assign sclk_oe = r_q.fl_act;
   assign flash_select_n = !r_q.fl_act;
   assign flash_mosi = r_q.fl_tx[7];

   assign chip_select_out_n = r_q.cso_n;

   // pull-ups only while configuring and not disabled
   assign pullup_enable = !pud_s && r_q.st != CS_DONE;

   // pins go to the user unless the port is kept
   assign user_io_enable = r_q.st == CS_DONE && !keep_port;

   // done wire also waits for the rest of a chain
   assign configured = r_q.st == CS_DONE && done_s;
   assign crc_error = r_q.crc_err;

endmodule // csp_top

//--- sim/csp_host_model.sv
/* host model: link clock, parallel and serial pins
   assumes the bench gates the clock with run and calls the tasks */
`timescale 1ns/1ps

module csp_host_model
   import csp_pkg::*;
(
   // clock gate from the bench
   input wire logic run,
   // device feedback
   input wire logic busy,
   // host pins
   output logic configuration_clock,
   output csp_par_s par,
   output logic serial_din
);
   // 30 ns link clock, parked low between frames
   initial begin
      configuration_clock = 1'b0;
      par = '{cs_n: 1'b1, read_write_n: 1'b0, data: 8'hA5};
      serial_din = 1'b0;
      #7;
      forever begin
         #15;
         if (run || configuration_clock) begin
            configuration_clock = ~configuration_clock;
         end
      end
   end

   // byte held until an edge with busy low takes it
   task send_par(input logic [7:0] b);
      int i;
      @(posedge configuration_clock);
      par <= '{cs_n: 1'b0, read_write_n: 1'b0, data: b};
      i = 0;
      do begin
         @(posedge configuration_clock);
         i++;
      end while (busy !== 1'b0 && i < 40);
      par.data <= ~b;
   endtask

   // msb first, one bit per rising edge
   task send_ser(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         @(posedge configuration_clock);
         serial_din <= b[k];
      end
   endtask

   // control pins, then free clocks for start-up or readback
   task ctl(input logic cs_n, input logic rw_n, input int n);
      @(posedge configuration_clock);
      par.cs_n <= cs_n;
      par.read_write_n <= rw_n;
      serial_din <= ~serial_din;
      repeat (n) @(posedge configuration_clock);
   endtask
endmodule // csp_host_model

//--- sim/csp_top_sva.sv
/* pin-level checks of the load port
   assumes it is bound onto csp_top and sees only its ports */
`timescale 1ns/1ps
`include "csp_defines.svh"

module csp_top_sva
   import csp_pkg::*;
(
   // clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic configuration_clock,
   // straps and host pins
   input wire logic [2:0] mode_select,
   input wire logic pullup_disable,
   input wire logic keep_port,
   input wire logic program_request_n,
   input wire csp_par_s par,
   // watched outputs
   input wire csp_od_s init_pin,
   input wire csp_od_s done_pin,
   input wire logic data_oe,
   input wire logic busy,
   input wire logic chip_select_out_n,
   input wire logic flash_select_n,
   input wire logic pullup_enable,
   input wire logic user_io_enable,
   input wire logic configured,
   input wire logic crc_error
);
   logic [5:0] prog_cnt_q;

   // low samples of the request, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prog_cnt_q <= 6'h00;
      end else if (program_request_n) begin
         prog_cnt_q <= 6'h00;
      end else if (prog_cnt_q != 6'h3F) begin
         prog_cnt_q <= prog_cnt_q + 6'h01;
      end
   end

   // pulse well under the abort width while configured
   sequence short_pulse;
      configured && program_request_n ##1 !program_request_n [*8] ##1 program_request_n;
   endsequence

   a_done_clean: assert property (@(posedge clk) disable iff (rst)
      !done_pin.oe |-> !init_pin.oe) else $error("done released beside init low");
   a_done_chain: assert property (@(posedge clk) disable iff (rst)
      $fell(done_pin.oe) |-> !chip_select_out_n) else $error("done before chain select");
   a_crc_init: assert property (@(posedge clk) disable iff (rst)
      crc_error |-> init_pin.oe && done_pin.oe) else $error("check error not shown");
   a_abort_clears: assert property (@(posedge clk) disable iff (rst)
      prog_cnt_q == 6'd20 |-> done_pin.oe && chip_select_out_n && !configured)
      else $error("long request did not clear");
   a_prog_holds: assert property (@(posedge clk) disable iff (rst)
      prog_cnt_q >= 6'd18 |-> init_pin.oe && flash_select_n) else $error("load while held");
   a_short_ignored: assert property (@(posedge clk) disable iff (rst)
      short_pulse |=> configured [*8]) else $error("short request acted on");
   a_pullup_off: assert property (@(posedge clk) disable iff (rst)
      pullup_disable [*4] |-> !pullup_enable) else $error("pull-ups despite disable");
   a_user_io: assert property (@(posedge clk) disable iff (rst)
      user_io_enable |-> !keep_port && !done_pin.oe) else $error("user pins too early");
   a_busy_cause: assert property (@(posedge configuration_clock) disable iff (rst)
      $rose(busy) && mode_select == `CSP_MODE_PAR |-> !$past(par.cs_n) && !$past(par.read_write_n))
      else $error("busy without a write");
   a_busy_ends: assert property (@(posedge configuration_clock) disable iff (rst)
      $rose(busy) |-> ##[1:12] !busy) else $error("busy stuck");
   a_readback_keep: assert property (@(posedge configuration_clock) disable iff (rst)
      data_oe |-> keep_port && !done_pin.oe) else $error("readback drive without keep");
endmodule // csp_top_sva

//--- sim/tb_config_slave_port.sv
/* bench of the load port: random loads, program pulses, bad check
   byte and flash commands; assumes the rtl files and the host model */
`timescale 1ns/1ps
`include "csp_defines.svh"

module tb_config_slave_port
   import csp_pkg::*;
;
   logic clk, rst, pullup_disable, keep_port, program_request_n, flash_miso, run;
   logic [2:0] mode_select, flash_variant_select;
   logic [15:0] load_length;
   logic configuration_clock, serial_din, busy, sclk_o, sclk_oe, data_oe, chip_select_out_n;
   logic flash_select_n, flash_mosi, pullup_enable, user_io_enable, configured, crc_error;
   logic init_i, done_i;
   logic [7:0] data_o;
   csp_par_s par;
   csp_od_s init_pin, done_pin;
   int errors, comparisons;

   // open-drain wires with pull-ups; only the device drives them
   assign init_i = ~init_pin.oe;
   assign done_i = ~done_pin.oe;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // flash answers noise; only the command is judged
   always @(posedge clk) flash_miso <= 1'($urandom);

   csp_top csp_top_inst (.clk, .rst, .mode_select, .flash_variant_select, .pullup_disable,
      .keep_port, .load_length, .program_request_n, .init_i, .init_pin, .done_i, .done_pin,
      .configuration_clock, .sclk_o, .sclk_oe, .par, .data_o, .data_oe, .busy,
      .chip_select_out_n, .serial_din, .flash_select_n, .flash_mosi, .flash_miso,
      .pullup_enable, .user_io_enable, .configured, .crc_error);
   csp_host_model csp_host_model_inst (.run, .busy, .configuration_clock, .par, .serial_din);

   task chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task stop_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // bounded wait: 0 init high, 1 configured, 2 chain select, 3 check error
   task wait_for(input int sel, input int lim);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk);
         hit = (sel == 0 ? init_i : sel == 1 ? configured
               : sel == 2 ? ~chip_select_out_n : crc_error) === 1'b1;
      end
      if (!hit) begin
         errors++;
         $display("unexpected at %0t: wait %0d ran out", $time, sel);
         stop_test();
      end
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      c = c ^ b;
      repeat (8) c = c[7] ? ((c << 1) ^ `CSP_CRC_POLY) : (c << 1);
      return c;
   endfunction

   // long request, new strap, then wait for init release
   task restart(input logic [2:0] m, input int w);
      mode_select <= m;
      load_length <= 16'(1 + $urandom % 6);
      program_request_n <= 1'b0;
      repeat (24) @(posedge clk);
      program_request_n <= 1'b1;
      wait_for(0, 300);
      repeat (w) @(posedge clk);
   endtask

   task send(input logic ser, input logic [7:0] b);
      if (ser) begin
         csp_host_model_inst.send_ser(b);
      end else begin
         csp_host_model_inst.send_par(b);
      end
   endtask

   // random data, then the check byte, optionally spoiled
   task load(input logic ser, input logic bad);
      logic [7:0] c;
      logic [7:0] b;
      c = `CSP_CRC_INIT;
      run = 1'b1;
      @(posedge configuration_clock); // enable sync edge
      for (int j = 0; j < int'(load_length); j++) begin
         b = 8'($urandom);
         c = crc8(c, b);
         send(ser, b);
      end
      send(ser, c ^ {7'h00, bad});
      csp_host_model_inst.ctl(ser, 1'b0, 30);
   endtask

   initial begin
      logic [7:0] got;
      logic pc;
      int k;
      errors = 0;
      comparisons = 0;
      void'($urandom(61511));
      rst = 1'b1;
      run = 1'b0;
      mode_select = `CSP_MODE_PAR;
      flash_variant_select = `CSP_FV_FAST;
      pullup_disable = 1'b0;
      keep_port = 1'b1;
      load_length = 16'h0001;
      program_request_n = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(init_pin.oe === 1'b1 && done_pin.oe === 1'b1, "clear state");
      chk(chip_select_out_n === 1'b1 && crc_error === 1'b0, "reset outputs");
      wait_for(0, 300);
      chk(pullup_enable === 1'b1, "pull-ups");
      repeat (6) @(posedge clk);
      $display("test reset done");
      // shortest parallel load, keep option on, then readback
      load(1'b0, 1'b0);
      wait_for(2, 100);
      wait_for(1, 200);
      chk(user_io_enable === 1'b0, "user pins with keep");
      csp_host_model_inst.ctl(1'b0, 1'b1, 12);
      chk(data_oe === 1'b1 && data_o === load.c, "readback drive");
      csp_host_model_inst.ctl(1'b1, 1'b0, 8);
      run = 1'b0;
      @(posedge clk);
      program_request_n <= 1'b0;
      repeat (8) @(posedge clk);
      program_request_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk(configured === 1'b1, "short pulse kept");
      $display("test parallel done");
      // serial load with keep option off
      keep_port <= 1'b0;
      restart(`CSP_MODE_SER, 6);
      chk(done_pin.oe === 1'b1, "done low after restart");
      load(1'b1, 1'b0);
      wait_for(1, 200);
      chk(user_io_enable === 1'b1, "user pins released");
      run = 1'b0;
      $display("test serial done");
      // spoiled check byte in parallel mode, pull-ups disabled
      pullup_disable <= 1'b1;
      restart(`CSP_MODE_PAR, 6);
      chk(pullup_enable === 1'b0, "pull-ups disabled");
      load(1'b0, 1'b1);
      wait_for(3, 100);
      chk(init_pin.oe === 1'b1 && configured === 1'b0, "error shown");
      run = 1'b0;
      $display("test check error done");
      // flash read command per variant
      for (int v = 0; v < 2; v++) begin
         flash_variant_select <= v ? `CSP_FV_READ : `CSP_FV_FAST;
         restart(`CSP_MODE_FLASH, 0);
         got = 8'h00;
         pc = 1'b0;
         k = 0;
         for (int i = 0; i < 400 && k < 8; i++) begin
            @(posedge clk);
            if (!flash_select_n && sclk_o && !pc) begin
               got = {got[6:0], flash_mosi};
               k++;
            end
            pc = sclk_o;
         end
         chk(got === (v ? `CSP_CMD_READ : `CSP_CMD_FAST) && sclk_oe === 1'b1, "command");
      end
      $display("test flash done");
      stop_test();
   end
endmodule // tb_config_slave_port

bind csp_top csp_top_sva csp_top_sva_inst (.clk, .rst, .configuration_clock, .mode_select,
   .pullup_disable, .keep_port, .program_request_n, .par, .init_pin, .done_pin, .data_oe,
   .busy, .chip_select_out_n, .flash_select_n, .pullup_enable, .user_io_enable,
   .configured, .crc_error);
